//--- chan_filter.sv
/*
 * Two-stage synchroniser and stability filter for both safety inputs.
 * Assumes raw inputs are asynchronous pins; outputs update in ref_clk domain.
 */
`timescale 1ns/10ps
module chan_filter
    import torque_cutoff_pkg::*;
(
    input  wire logic        ref_clk,        // Control clock.
    input  wire logic        rst_n,          // Asynchronous reset, active low.
    input  wire logic        safe_input_a,   // Raw channel A pin, 1 = closed.
    input  wire logic        safe_input_b,   // Raw channel B pin, 1 = closed.
    torque_chan_if.filt_src  ch              // Filtered channel levels.
);

    typedef struct packed {
        logic [1:0]             sync1;
        logic [1:0]             sync2;
        logic [1:0][FILT_W-1:0] cnt;
        logic [1:0]             filt;
    } filt_state_t;

    filt_state_t st_r;
    filt_state_t st_nxt;

    // Synchronise, then accept a new level only after it held FILTER_CYC cycles.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = {safe_input_b, safe_input_a};
        st_nxt.sync2 = st_r.sync1;                          // R18
        for (int i = 0; i < 2; i++) begin
            if (st_r.sync2[i] == st_r.filt[i]) begin
                st_nxt.cnt[i] = '0;
            end else if (st_r.cnt[i] == FILTER_CYC - 12'h1) begin
                st_nxt.filt[i] = st_r.sync2[i];             // R18
                st_nxt.cnt[i]  = '0;
            end else begin
                st_nxt.cnt[i] = st_r.cnt[i] + 12'h1;
            end
        end
    end

    // Reset leaves both channels open, so the drive stays off until inputs settle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch.a_closed = st_r.filt[0];
    assign ch.b_closed = st_r.filt[1];

    // A filtered level moves only after the full stable count.
    AST_FILTER_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)   // R18
        $changed(st_r.filt) |-> ($past(st_r.cnt[0]) == FILTER_CYC - 12'h1)
                             || ($past(st_r.cnt[1]) == FILTER_CYC - 12'h1))
        else $error("Filtered channel changed before the stable count elapsed.");

endmodule

//--- safety_switch_model.sv
/*
 * Model of the external safety contacts that feed both safety channels.
 * Assumes the bench commands each contact level; 1 means closed.
 */
`timescale 1ns/10ps
module safety_switch_model #(
    parameter realtime MOVE_NS = 137.3   // Contact travel time, far below 200 ms.
)
(
    input  wire logic cmd_a,          // Wanted level of contact A.
    input  wire logic cmd_b,          // Wanted level of contact B.
    input  wire logic bypass,         // Jumpers fitted, both always closed.
    output logic      safe_input_a,   // Contact A to the drive pin.
    output logic      safe_input_b    // Contact B to the drive pin.
);
    // Each contact settles a fixed time after its command, off the clock grid.
    always @(cmd_a or bypass) begin
        safe_input_a <= #MOVE_NS (bypass | cmd_a);
    end

    // Channel B moves on its own, so skewed openings can be made.
    always @(cmd_b or bypass) begin
        safe_input_b <= #MOVE_NS (bypass | cmd_b);
    end
endmodule

//--- tb.sv
/*
 * Self-checking bench for the torque cutoff monitor.
 * Assumes the contact model file is compiled first; mismatch window shortened to 50.
 */
`timescale 1ns/10ps
module tb;
    import torque_cutoff_pkg::*;
    localparam int unsigned DISC   = 50;
    localparam int unsigned SETTLE = 2200;
    localparam int unsigned TRIG_C = TRIG_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned OPEN_C = IND_OPEN_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned FLT_C  = IND_FAULT_MS * (CLK_HZ / MS_PER_S);
    typedef struct packed { logic rst, a, b, key, drv, cut; logic [2:0] code; } row_t;
    logic       ref_clk, rst_n, cmd_a, cmd_b, key, start_cmd, stop_cmd, auto_p;
    logic       safe_a, safe_b, drive_enable, cutoff_active, bypass;
    logic [2:0] display_code;
    int         error_cnt, samples_checked;
    row_t       rows [10];

    safety_switch_model i_sw (.cmd_a(cmd_a), .cmd_b(cmd_b), .bypass(bypass),
        .safe_input_a(safe_a), .safe_input_b(safe_b));
    torque_cutoff_monitor #(.DISC_CYCLES(DISC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .safe_input_a(safe_a), .safe_input_b(safe_b), .stop_reset_key(key), .start_cmd(start_cmd),
        .stop_cmd(stop_cmd), .auto_fault_reset_param(auto_p), .drive_enable(drive_enable),
        .cutoff_active(cutoff_active), .display_code(display_code));

    // Control clock at 40 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int unsigned n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic chk_code(input logic [2:0] exp);
        samples_checked++;
        if (display_code !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: code got %h expected %h", $time, display_code, exp);
        end
    endtask
    task automatic pulse(input int sel);
        if (sel == 0) key = 1'b1; else if (sel == 1) start_cmd = 1'b1; else stop_cmd = 1'b1;
        cyc(1);
        {key, start_cmd, stop_cmd} = 3'h0;
        cyc(4);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        cyc(3);
        chk_bit(cutoff_active, 1'b1, "reset cutoff");
        chk_bit(drive_enable, 1'b0, "reset drive");
        rst_n = 1'b1;
    endtask
    // Apply one row: contacts, optional key, then a start attempt, then the check.
    task automatic run_row(input row_t r);
        if (r.rst) do_reset();
        cmd_a = r.a;
        cmd_b = r.b;
        cyc(SETTLE);
        if (r.key) pulse(0);
        pulse(1);
        chk_bit(drive_enable, r.drv, "drive");
        chk_bit(cutoff_active, r.cut, "cutoff");
        chk_code(r.code);
    endtask
    // Count cycles until drive is off (sel 0) or the code shows; the limit is the bound.
    task automatic time_to(input int sel, input logic [2:0] want, input int unsigned lim);
        int unsigned n;
        n = 0;
        while (!(sel == 0 ? drive_enable === 1'b0 : display_code === want) && n < lim) begin
            cyc(1);
            n++;
        end
        chk_bit(n < lim, 1'b1, "response bound");
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog at 80k cycles, well beyond the expected 40k cycles.
    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end

    // Main sequence: table rows first, then timing and filter cases.
    initial begin
        {rst_n, cmd_a, cmd_b, key, start_cmd, stop_cmd, auto_p, bypass} = 8'h00;
        error_cnt = 0;
        samples_checked = 0;
        rows = '{'{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, CODE_NONE},
                 '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, CODE_DUAL_OPEN},
                 '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, CODE_DUAL_OPEN},
                 '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, CODE_NONE},
                 '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, CODE_CHAN_A},
                 '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, CODE_CHAN_A},
                 '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, CODE_NONE},
                 '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, CODE_CHAN_B},
                 '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, CODE_CHAN_B},
                 '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, CODE_DUAL_FAULT}};
        cyc(1);
        foreach (rows[i]) run_row(rows[i]);
        // Channel A fault from running: cut and indication bounds.
        run_row(rows[0]);
        cmd_a = 1'b0;
        time_to(0, CODE_NONE, TRIG_C);
        time_to(1, CODE_CHAN_A, FLT_C);
        // Commanded dual-open from running: cut and indication bounds.
        run_row(rows[0]);
        {cmd_a, cmd_b} = 2'b00;
        time_to(0, CODE_NONE, TRIG_C);
        time_to(1, CODE_DUAL_OPEN, OPEN_C);
        // Automatic clear once both contacts close again.
        auto_p = 1'b1;
        {cmd_a, cmd_b} = 2'b11;
        cyc(SETTLE);
        chk_bit(cutoff_active, 1'b0, "auto clear");
        chk_code(CODE_NONE);
        // A short open glitch on A is filtered out while running.
        pulse(1);
        cmd_a = 1'b0;
        cyc(100);
        cmd_a = 1'b1;
        cyc(SETTLE);
        chk_bit(drive_enable, 1'b1, "glitch");
        chk_code(CODE_NONE);
        // A stop command ends the run; a fresh start sets up the skew case.
        pulse(2);
        chk_bit(drive_enable, 1'b0, "stop");
        chk_bit(cutoff_active, 1'b0, "stop cut");
        pulse(1);
        // Skewed opening inside the window counts as commanded, not a fault.
        cmd_a = 1'b0;
        cyc(20);
        cmd_b = 1'b0;
        cyc(SETTLE);
        chk_bit(drive_enable, 1'b0, "skew drive");
        chk_code(CODE_DUAL_OPEN);
        // Jumpers fitted: both channels read closed, the automatic clear applies and the drive runs.
        bypass = 1'b1;
        cyc(SETTLE);
        pulse(1);
        chk_bit(drive_enable, 1'b1, "bypass");
        chk_code(CODE_NONE);
        complete_run();
    end
endmodule

//--- torque_chan_if.sv
/*
 * Carries the filtered safety channel levels from the input filter to the
 * monitor. Both levels are in the control clock domain; 1 means closed.
 */
`timescale 1ns/10ps
interface torque_chan_if;
    logic a_closed;   // Filtered channel A, 1 = closed.
    logic b_closed;   // Filtered channel B, 1 = closed.

    modport filt_src (output a_closed, output b_closed);
    modport mon_dst  (input a_closed, input b_closed);
endinterface

//--- torque_cutoff_monitor.sv
/*
 * Dual-channel torque cutoff monitor: judges the two safety channels, cuts
 * the drive enable, latches fault codes and gates start commands.
 * Assumes start/stop commands and the auto-reset setting come from logic on
 * ref_clk; the keypad stop/reset key and safety inputs are asynchronous pins.
 */
`timescale 1ns/10ps
module torque_cutoff_monitor
    import torque_cutoff_pkg::*;
#(
    parameter int unsigned DISC_CYCLES = DISC_CYC_DFLT   // Channel mismatch window.
)
(
    input  wire logic       ref_clk,                // Control clock, 40 MHz.
    input  wire logic       rst_n,                  // Power-on reset, active low.
    input  wire logic       safe_input_a,           // Safety channel A pin, 1 = closed.
    input  wire logic       safe_input_b,           // Safety channel B pin, 1 = closed.
    input  wire logic       stop_reset_key,         // Keypad stop/reset key pin, 1 = pressed.
    input  wire logic       start_cmd,              // Start request pulse.
    input  wire logic       stop_cmd,               // Stop request pulse.
    input  wire logic       auto_fault_reset_param, // Auto-clear of the commanded-cutoff code.
    output logic            drive_enable,           // Gate drive permitted, 1 = drive.
    output logic            cutoff_active,          // Torque cutoff in force.
    output logic [2:0]      display_code            // Keypad fault code.
);

    typedef enum logic [1:0] {ST_READY, ST_RUNNING, ST_CUTOFF} run_state_t;

    typedef struct packed {
        run_state_t       state;
        logic [1:0]       key_sync;
        logic             key_prev;
        logic [DISC_W-1:0] disc_cnt;
        logic             fault_a;
        logic             fault_b;
        logic             dual_open;
        logic             drive_en;
        logic             cutoff;
        logic [2:0]       code;
    } mon_state_t;

    localparam logic [DISC_W-1:0] DISC_LAST = DISC_W'(DISC_CYCLES - 1);

    torque_chan_if ch ();

    mon_state_t st_r;
    mon_state_t st_nxt;

    logic a_cl;
    logic b_cl;
    logic both_open;
    logic mismatch;
    logic key_pulse;
    logic cut_nxt;

    // Input synchroniser and filter for both safety channels.
    chan_filter u_filter (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .safe_input_a (safe_input_a),
        .safe_input_b (safe_input_b),
        .ch           (ch.filt_src)
    );

    // Channel comparisons, made on the filtered levels in one cycle.
    assign a_cl      = ch.a_closed;
    assign b_cl      = ch.b_closed;
    assign both_open = !a_cl && !b_cl;
    assign mismatch  = a_cl ^ b_cl;                                    // R18
    assign key_pulse = st_r.key_sync[1] && !st_r.key_prev;

    // Picks the keypad code; a latched channel fault outranks the commanded cutoff.
    function automatic logic [2:0] pick_code(input logic fa, input logic fb, input logic dop);
        logic [2:0] c;
        c = CODE_NONE;                                                  // R1
        if (fa && fb) begin
            c = CODE_DUAL_FAULT;                                        // R6
        end else if (fa) begin
            c = CODE_CHAN_A;                                            // R4
        end else if (fb) begin
            c = CODE_CHAN_B;                                            // R5
        end else if (dop) begin
            c = CODE_DUAL_OPEN;                                         // R2
        end
        return c;
    endfunction

    // Next-state logic for fault judgement, code latches and run control.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.key_sync = {st_r.key_sync[0], stop_reset_key};
        st_nxt.key_prev = st_r.key_sync[1];

        // Mismatch longer than the contact window marks the open channel abnormal.
        if (!mismatch) begin
            st_nxt.disc_cnt = '0;
        end else if (st_r.disc_cnt == DISC_LAST) begin
            st_nxt.disc_cnt = st_r.disc_cnt + 24'h1;                   // R13
            if (!a_cl) begin
                st_nxt.fault_a = 1'b1;                                  // R4 R8 R16
            end else begin
                st_nxt.fault_b = 1'b1;                                  // R5 R8 R16
            end
        end else if (st_r.disc_cnt < DISC_LAST) begin
            st_nxt.disc_cnt = st_r.disc_cnt + 24'h1;
        end
        // Channel faults have no clear path other than reset.

        // Commanded cutoff latch: setting wins over a clear in the same cycle.
        if (both_open) begin
            st_nxt.dual_open = 1'b1;                                    // R2 R3 R10
        end else if (key_pulse || auto_fault_reset_param) begin
            st_nxt.dual_open = 1'b0;                                    // R15
        end

        cut_nxt = !(a_cl && b_cl) || st_nxt.fault_a || st_nxt.fault_b
                  || st_nxt.dual_open;                                  // R12 R14

        // Cutoff overrides every command; starts are dropped while it holds.
        case (st_r.state)
            ST_READY: begin
                if (cut_nxt) begin
                    st_nxt.state = ST_CUTOFF;                           // R12
                end else if (start_cmd) begin
                    st_nxt.state = ST_RUNNING;                          // R1
                end
            end
            ST_RUNNING: begin
                if (cut_nxt) begin
                    st_nxt.state = ST_CUTOFF;                           // R17 R7 R9
                end else if (stop_cmd || key_pulse) begin
                    st_nxt.state = ST_READY;
                end
            end
            ST_CUTOFF: begin
                if (!cut_nxt) begin
                    st_nxt.state = ST_READY;                            // R11
                end
            end
            default: begin
                st_nxt.state = ST_CUTOFF;
            end
        endcase

        st_nxt.cutoff   = cut_nxt;
        st_nxt.drive_en = (st_nxt.state == ST_RUNNING);                 // R11 R17
        st_nxt.code     = pick_code(st_nxt.fault_a, st_nxt.fault_b, st_nxt.dual_open);
    end

    // Reset starts in cutoff with the drive off, the safe state.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r        <= '0;
            st_r.state  <= ST_CUTOFF;
            st_r.cutoff <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    assign drive_enable  = st_r.drive_en;
    assign cutoff_active = st_r.cutoff;
    assign display_code  = st_r.code;

    default clocking mon_clk @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Filtered inputs both closed with no channel fault latched.
    sequence seq_clean;
        a_cl && b_cl && !st_r.fault_a && !st_r.fault_b;
    endsequence

    // A clear request arriving after both channels closed again.
    sequence seq_clear_req;
        seq_clean and (st_r.dual_open && (key_pulse || auto_fault_reset_param));
    endsequence

    // A channel mismatch reaching the end of the contact window.
    sequence seq_window_end(logic open_a);
        mismatch && (st_r.disc_cnt == DISC_LAST) && (!a_cl == open_a);
    endsequence

    AST_OPEN_CUTS_DRIVE: assert property (!(a_cl && b_cl) |=> !drive_enable && cutoff_active) // R7
        else $error("Drive not cut the cycle after a channel opened.");

    AST_DUAL_OPEN_CODE: assert property (both_open && !st_r.fault_a && !st_r.fault_b  // R10
        |=> display_code == CODE_DUAL_OPEN && !drive_enable)
        else $error("Commanded cutoff code not shown after both channels opened.");

    AST_NO_START_IN_CUTOFF: assert property (cutoff_active && start_cmd |=> !drive_enable) // R11
        else $error("Start command accepted during cutoff.");

    AST_CLEAN_RUN: assert property (seq_clean and (st_r.state == ST_READY && !st_r.dual_open && start_cmd) // R1
        |=> drive_enable && display_code == CODE_NONE)
        else $error("Clean start did not enable the drive.");

    AST_CHAN_A_FAULT: assert property (seq_window_end(1'b1) and !st_r.fault_b           // R4
        |=> display_code == CODE_CHAN_A ##1 st_r.fault_a)
        else $error("Channel A fault not flagged at end of window.");

    AST_CHAN_B_FAULT: assert property (seq_window_end(1'b0) and !st_r.fault_a           // R5
        |=> display_code == CODE_CHAN_B ##1 st_r.fault_b)
        else $error("Channel B fault not flagged at end of window.");

    AST_DUAL_FAULT: assert property (st_r.fault_a && st_r.fault_b                       // R6
        |=> display_code == CODE_DUAL_FAULT && display_code != CODE_DUAL_OPEN)
        else $error("Dual channel fault code wrong.");

    AST_FAULT_STAYS: assert property ($rose(st_r.fault_a) |-> (st_r.fault_a && !drive_enable)[*8]) // R16
        else $error("Channel fault did not stay latched.");

    AST_OPEN_CLEAR: assert property (seq_clear_req |=> display_code == CODE_NONE && !cutoff_active) // R15
        else $error("Commanded cutoff code not cleared by reset request.");

    AST_CUTOFF_PRIORITY: assert property (drive_enable |-> !cutoff_active && st_r.state == ST_RUNNING) // R17
        else $error("Drive enabled while cutoff active.");

endmodule

//--- torque_cutoff_pkg.sv
/*
 * Shared constants for the dual-channel torque cutoff monitor: clock rate,
 * filter and discrepancy timing, response bounds and the keypad code values.
 * Assumes a single 40 MHz control clock feeding every module of the block.
 */
// Notes on behaviour
// R1: Both safety inputs closed permits running and shows no fault code.
// R2: Both inputs open together cuts the output and shows the commanded-cutoff code.
// R3: After the switch opens and output stops, the commanded-cutoff code is displayed.
// R4: Input A open with B closed cuts output and flags channel A abnormal.
// R5: Input B open with A closed cuts output and flags channel B abnormal.
// R6: Both channels abnormal shows its own code, distinct from the commanded cutoff.
// R7: Any channel fault switches the output off within 10 ms.
// R8: Channel fault indication appears within 280 ms of the triggering change.
// R9: Commanded dual-open cutoff switches the output off within 10 ms.
// R10: Commanded dual-open indication appears within 100 ms of both inputs opening.
// R11: Start commands are ignored and output stays off while cutoff is active.
// R12: Opening of the cutoff circuit enters cutoff and stops driving the motor.
// R13: External contacts finish each open or close transition within 200 ms.
// R14: Installer disables cutoff by tying both inputs permanently to supply.
// R15: Commanded-cutoff code clears on stop/reset key, or automatically if enabled.
// R16: Single-channel fault codes stay latched until a full power cycle.
// R17: Torque cutoff overrides every run, speed or torque command.
// R18: Each input is synchronised and briefly filtered before channels are compared.
package torque_cutoff_pkg;

    // Clock rate and unit divisors.
    localparam int unsigned CLK_HZ    = 32'h0262_5A00;   // 40 MHz.
    localparam int unsigned US_PER_S  = 32'h000F_4240;
    localparam int unsigned MS_PER_S  = 32'h0000_03E8;

    // Input glitch filter: 50 us of stable level, rounded down.
    localparam int unsigned FILTER_US  = 32'h32;
    localparam int unsigned FILT_W     = 12;
    localparam logic [FILT_W-1:0] FILTER_CYC = FILT_W'(FILTER_US * (CLK_HZ / US_PER_S));

    // Contact transition window: a channel mismatch longer than this is a fault.
    localparam int unsigned DISC_MS        = 32'hC8;
    localparam int unsigned DISC_W         = 24;
    localparam int unsigned DISC_CYC_DFLT  = DISC_MS * (CLK_HZ / MS_PER_S);

    // Response bounds of the block, kept for reference by checks.
    localparam int unsigned TRIG_MS       = 32'h0A;
    localparam int unsigned IND_OPEN_MS   = 32'h64;
    localparam int unsigned IND_FAULT_MS  = 32'h118;

    // Keypad code values presented on display_code.
    localparam logic [2:0] CODE_NONE       = 3'h0;
    localparam logic [2:0] CODE_DUAL_OPEN  = 3'h1;
    localparam logic [2:0] CODE_CHAN_A     = 3'h2;
    localparam logic [2:0] CODE_CHAN_B     = 3'h3;
    localparam logic [2:0] CODE_DUAL_FAULT = 3'h4;

endpackage
